// >>> lin_phy_pkg.sv
/*
  Constants and types for the LIN physical-layer control logic.
  Assumes a single 40 MHz base clock and a synchronous active-high reset.
*/
// Summary of operation
// - A two-bit field selects the slew rate: 10 kbit/s, 20 kbit/s or fast 100 kbit/s.
// - After reset the slew selection is the 20 kbit/s setting.
// - Over-temperature shuts the transmitter down and the condition flag follows it.
// - With the enable bit set, a rising over-temperature condition raises an interrupt.
// - A read of the transceiver register acknowledges and drops the interrupt request.
// - A new interrupt needs the condition to vanish and then occur again.
// - The transmitter comes back once the condition is gone and transmit input is high.
// - In low-power modes, a dominant longer than the wake filter time then a rising edge records a wake event.
// - In low-power modes the transmitter stays disabled.
// - In low-power modes the receiver stays active to see wake activity.
// - The undervoltage hold behaviour applies only while the shutdown select bit is zero.
// - Undervoltage while recessive holds the driver recessive.
// - Undervoltage while dominant waits for the next rising transmit edge, then holds.
// - After undervoltage, driving resumes when transmit is recessive or on its next rise.
package lin_phy_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Slew-rate encodings.
  localparam logic [1:0] SLEW_20K = 2'h0;
  localparam logic [1:0] SLEW_10K = 2'h1;
  localparam logic [1:0] SLEW_FAST = 2'h2;
  localparam logic [1:0] SLEW_RESET = SLEW_20K;

  ////////////////////////////////////////////////////////////////////////////////
  // Timing.
  localparam int CLK_HZ = 40000000;
  localparam int WAKE_FILTER_NS = 100000;
  localparam int WAKE_FILTER_CYC = (WAKE_FILTER_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int SYNC_STAGES = 3;

  // Undervoltage hold states.
  typedef enum logic [1:0] {UV_NORMAL, UV_WAIT_RISE, UV_HOLD, UV_RESUME_WAIT} uvState_t;

endpackage

// >>> sync3.sv
/*
  Three-stage level synchroniser with agreement of the last two stages.
  Assumes the input is asynchronous to clk.
*/
`timescale 1ns/10ps
module sync3 #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic din,
  output logic dout
);
  typedef struct packed {
    logic [2:0] stage;
    logic level;
  } syncState_t;

  syncState_t st_reg;
  syncState_t st_next;

  // The first stage feeds only the second; the output changes once stages two and three agree.
  always_comb begin
    st_next = st_reg;
    st_next.stage = {st_reg.stage[1:0], din};
    if (st_reg.stage[1] == st_reg.stage[2]) begin
      st_next.level = st_reg.stage[2];
    end
  end

  // State register.
  always_ff @(posedge clk) begin
    if (reset) begin
      st_reg <= '{stage: {3{RESET_VAL}}, level: RESET_VAL};
    end else begin
      st_reg <= st_next;
    end
  end

  assign dout = st_reg.level;
endmodule // sync3

// >>> lin_phy_control_logic.sv
/*
  Control logic of a LIN transceiver: slew select, over-temperature shutdown and interrupt,
  wake detection in low power, and undervoltage recessive hold.
  Assumes the analog front end drives overTemp, undervoltage and busRx asynchronously.
*/
`timescale 1ns/10ps
module lin_phy_control_logic
  import lin_phy_pkg::*;
#(
  parameter int WAKE_CYCLES = lin_phy_pkg::WAKE_FILTER_CYC
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic txIn,
  input wire logic busRx,
  input wire logic overTemp,
  input wire logic supplyUndervoltageIndication,
  input wire logic undervoltageShutdownSelect,
  input wire logic lowPower,
  input wire logic [1:0] slewWrite,
  input wire logic slewWriteStrobe,
  input wire logic overtempIrqEnableIn,
  input wire logic transceiverRead,
  input wire logic wakeSourceRead,
  output logic [1:0] slewSelect,
  output logic overtempConditionFlag,
  output logic overtempIrqEnable,
  output logic overtempIrq,
  output logic wakeSourceRegister,
  output logic wakeEvent,
  output logic driveDominant,
  output logic txEnable,
  output logic rxEnable,
  output logic rxOut
);
  import lin_phy_pkg::*;

  // The dominant counter is 16 bits wide, so longer filters are refused at elaboration.
  if (WAKE_CYCLES < 1 || WAKE_CYCLES > 65535) begin : gBadWakeCycles
    $error("WAKE_CYCLES out of range");
  end

  typedef struct packed {
    logic [1:0] slew;
    logic irqEn;
    logic irq;
    logic otArmed;
    logic txOff;
    logic txPrev;
    logic rxPrev;
    logic [15:0] domCount;
    logic domLong;
    logic wakeFlag;
    logic wakePulse;
    uvState_t uv;
    logic drive;
    logic rxQ;
  } ctrl_t;

  ctrl_t s_reg;
  ctrl_t s_next;
  logic otSync;
  logic uvSync;
  logic rxSync;
  logic txRise;
  logic uvActive;

  ////////////////////////////////////////////////////////////////////////////////
  // input synchronisers
  sync3 #(.RESET_VAL(1'b0)) otSyncInst (.clk(clk), .reset(reset), .din(overTemp), .dout(otSync));
  sync3 #(.RESET_VAL(1'b0)) uvSyncInst (.clk(clk), .reset(reset),
    .din(supplyUndervoltageIndication), .dout(uvSync));
  sync3 #(.RESET_VAL(1'b1)) rxSyncInst (.clk(clk), .reset(reset), .din(busRx), .dout(rxSync));

  // Transmit is same-domain logic; a rise means dominant-to-recessive.
  assign txRise = txIn && !s_reg.txPrev;
  assign uvActive = uvSync && !undervoltageShutdownSelect;

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic for every function of the block.
  always_comb begin
    s_next = s_reg;
    s_next.txPrev = txIn;
    s_next.rxPrev = rxSync;
    s_next.wakePulse = 1'b0;
    s_next.rxQ = rxSync;
    if (slewWriteStrobe) begin
      s_next.slew = slewWrite;
    end
    s_next.irqEn = overtempIrqEnableIn;
    // read acknowledges; a fresh event in the same cycle still wins
    if (transceiverRead) begin
      s_next.irq = 1'b0;
    end
    if (otSync && s_reg.otArmed) begin
      s_next.otArmed = 1'b0;
      if (s_reg.irqEn) begin
        s_next.irq = 1'b1;
      end
    end else if (!otSync) begin
      s_next.otArmed = 1'b1;
    end
    // shutdown and re-enable on high transmit input
    if (otSync) begin
      s_next.txOff = 1'b1;
    end else if (txIn) begin
      s_next.txOff = 1'b0;
    end
    // dominant length filter then rising edge
    if (!rxSync) begin
      if (s_reg.domCount != 16'(WAKE_CYCLES)) begin
        s_next.domCount = s_reg.domCount + 16'h0001;
      end else begin
        s_next.domLong = 1'b1;
      end
    end else begin
      s_next.domCount = 16'h0000;
      s_next.domLong = 1'b0;
      if (!s_reg.rxPrev && s_reg.domLong && lowPower) begin
        s_next.wakePulse = 1'b1;
      end
    end
    if (wakeSourceRead) begin
      s_next.wakeFlag = 1'b0;
    end
    if (s_next.wakePulse) begin
      s_next.wakeFlag = 1'b1;
    end
    unique case (s_reg.uv)
      UV_NORMAL: begin
        if (uvActive) begin
          s_next.uv = (txIn || txRise) ? UV_HOLD : UV_WAIT_RISE;
        end
      end
      UV_WAIT_RISE: begin
        if (txRise) begin
          s_next.uv = uvActive ? UV_HOLD : UV_NORMAL;
        end
      end
      UV_HOLD: begin
        if (!uvActive) begin
          s_next.uv = txIn ? UV_NORMAL : UV_RESUME_WAIT;
        end
      end
      UV_RESUME_WAIT: begin
        if (uvActive) begin
          s_next.uv = UV_HOLD;
        end else if (txRise) begin
          s_next.uv = UV_NORMAL;
        end
      end
    endcase
    // low power and shutdowns force recessive
    s_next.drive = !txIn && !lowPower && !s_next.txOff &&
      (s_next.uv == UV_NORMAL || s_next.uv == UV_WAIT_RISE);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register.
  always_ff @(posedge clk) begin
    if (reset) begin
      s_reg <= '{slew: SLEW_RESET, irqEn: 1'b0, irq: 1'b0, otArmed: 1'b1, txOff: 1'b0,
        txPrev: 1'b1, rxPrev: 1'b1, domCount: 16'h0000, domLong: 1'b0, wakeFlag: 1'b0,
        wakePulse: 1'b0, uv: UV_NORMAL, drive: 1'b0, rxQ: 1'b1};
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs.
  assign slewSelect = s_reg.slew;
  assign overtempConditionFlag = otSync;
  assign overtempIrqEnable = s_reg.irqEn;
  assign overtempIrq = s_reg.irq;
  assign wakeSourceRegister = s_reg.wakeFlag;
  assign wakeEvent = s_reg.wakePulse;
  assign driveDominant = s_reg.drive;
  assign txEnable = !s_reg.txOff && !lowPower;
  assign rxEnable = 1'b1;
  assign rxOut = s_reg.rxQ;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions.
  sequence otRiseArmed;
    otSync && s_reg.otArmed && s_reg.irqEn;
  endsequence

  a_ot_irq_raise: assert property (@(posedge clk) disable iff (reset)
    otRiseArmed |=> overtempIrq) else $error("irq not raised");
  a_ot_no_retrigger: assert property (@(posedge clk) disable iff (reset)
    (otSync && !s_reg.otArmed && !overtempIrq) |=> !overtempIrq) else $error("irq retriggered");
  a_read_ack: assert property (@(posedge clk) disable iff (reset)
    (transceiverRead && !(otSync && s_reg.otArmed)) |=> !overtempIrq) else $error("ack ignored");
  a_ot_shutdown: assert property (@(posedge clk) disable iff (reset)
    otSync |=> !driveDominant && !txEnable) else $error("tx on in overtemp");
  a_tx_reenable: assert property (@(posedge clk) disable iff (reset)
    (!otSync && txIn && !lowPower) |=> (txEnable || lowPower)) else $error("tx not re-enabled");
  a_lowpower_off: assert property (@(posedge clk) disable iff (reset)
    lowPower |=> !driveDominant) else $error("drive in low power");
  a_uv_hold: assert property (@(posedge clk) disable iff (reset)
    (s_reg.uv == UV_HOLD) |-> !driveDominant) else $error("drive during hold");
  a_wake_filter: assert property (@(posedge clk) disable iff (reset)
    wakeEvent |-> $past(s_reg.domLong)) else $error("wake without filter");
  a_slew_reset: assert property (@(posedge clk)
    $past(reset) |-> slewSelect == SLEW_RESET) else $error("slew reset wrong");
endmodule // lin_phy_control_logic

// >>> lin_bus_model.sv
/*
  Bus model: a pulled-up LIN line shared with one other node.
  Assumes driveDominant is high while the control logic pulls the line low.
*/
`timescale 1ns/10ps
module lin_bus_model (
  input wire logic driveDominant,
  input wire logic nodeDominant,
  output logic busRx
);
  // The pull-up makes a released line recessive; either driver wins dominant.
  assign busRx = ~(driveDominant | nodeDominant);
endmodule // lin_bus_model

// >>> tb_lin_phy_control_logic.sv
/*
  Testbench for the LIN control logic: scenario calls with expected values.
  Assumes a 40 MHz clock and a short wake filter so the run stays brief.
*/
`timescale 1ns/10ps
module tb_lin_phy_control_logic;
  import lin_phy_pkg::*;
  localparam int WAKE = 8;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic txIn = 1'b1, overTemp = 1'b0, uv = 1'b0, uvSel = 1'b0, lowPower = 1'b0;
  logic [1:0] slewWrite = 2'h0;
  logic slewWriteStrobe = 1'b0, otIe = 1'b0, trRead = 1'b0, wsRead = 1'b0, nodeDom = 1'b0;
  logic [1:0] slewSelect;
  logic otFlag, otIeOut, otIrq, wakeReg, wakeEvent, driveDominant, txEnable, rxEnable;
  logic rxOut, busRx, seen;
  logic [1:0] codes [3] = '{SLEW_10K, SLEW_FAST, SLEW_20K};
  int errors = 0;
  int n_compared = 0;

  always #12.5 clk = ~clk;

  lin_phy_control_logic #(.WAKE_CYCLES(WAKE)) lin_phy_control_logic_inst (
    .clk(clk), .reset(reset), .txIn(txIn), .busRx(busRx), .overTemp(overTemp),
    .supplyUndervoltageIndication(uv), .undervoltageShutdownSelect(uvSel),
    .lowPower(lowPower), .slewWrite(slewWrite), .slewWriteStrobe(slewWriteStrobe),
    .overtempIrqEnableIn(otIe), .transceiverRead(trRead), .wakeSourceRead(wsRead),
    .slewSelect(slewSelect), .overtempConditionFlag(otFlag), .overtempIrqEnable(otIeOut),
    .overtempIrq(otIrq), .wakeSourceRegister(wakeReg), .wakeEvent(wakeEvent),
    .driveDominant(driveDominant), .txEnable(txEnable), .rxEnable(rxEnable), .rxOut(rxOut)
  );

  lin_bus_model lin_bus_model_inst (
    .driveDominant(driveDominant), .nodeDominant(nodeDom), .busRx(busRx)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Case equality keeps an unknown from passing as a match.
  task automatic check(input string nm, input logic [1:0] s, input logic [1:0] e);
    n_compared++;
    if (s !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic chk(input string nm, input logic s, input logic e);
    check(nm, {1'b0, s}, {1'b0, e});
  endtask

  // Inputs change only at falling edges, so every posedge sees settled values.
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  // One-cycle read pulse of the transceiver or the wake source register.
  task automatic rd(input logic ws);
    trRead = ~ws;
    wsRead = ws;
    tick(1);
    trRead = 1'b0;
    wsRead = 1'b0;
    tick(1);
  endtask

  task automatic wrap_up;
    if (errors == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Six cycles cover the three synchroniser stages plus the register behind them.
  initial begin
    tick(5);
    reset = 1'b0;
    tick(1);
    check("slewSelect", slewSelect, SLEW_RESET);
    foreach (codes[i]) begin
      slewWrite = codes[i];
      slewWriteStrobe = 1'b1;
      tick(1);
      slewWriteStrobe = 1'b0;
      tick(1);
      check("slewSelect", slewSelect, codes[i]);
    end
    otIe = 1'b1;
    txIn = 1'b0;
    tick(2);
    chk("otIeOut", otIeOut, 1'b1);
    chk("driveDominant", driveDominant, 1'b1);
    overTemp = 1'b1;
    tick(6);
    chk("otFlag", otFlag, 1'b1);
    chk("driveDominant", driveDominant, 1'b0);
    chk("txEnable", txEnable, 1'b0);
    chk("otIrq", otIrq, 1'b1);
    rd(1'b0);
    chk("otIrq", otIrq, 1'b0);
    tick(10);
    chk("otIrq", otIrq, 1'b0);
    chk("otFlag", otFlag, 1'b1);
    overTemp = 1'b0;
    tick(6);
    chk("otFlag", otFlag, 1'b0);
    chk("driveDominant", driveDominant, 1'b0);
    chk("txEnable", txEnable, 1'b0);
    txIn = 1'b1;
    tick(2);
    chk("txEnable", txEnable, 1'b1);
    txIn = 1'b0;
    tick(2);
    chk("driveDominant", driveDominant, 1'b1);
    overTemp = 1'b1;
    tick(6);
    chk("otIrq", otIrq, 1'b1);
    overTemp = 1'b0;
    tick(6);
    rd(1'b0);
    lowPower = 1'b1;
    tick(2);
    chk("txEnable", txEnable, 1'b0);
    chk("driveDominant", driveDominant, 1'b0);
    chk("rxEnable", rxEnable, 1'b1);
    txIn = 1'b1;
    nodeDom = 1'b1;
    tick(WAKE / 2);
    nodeDom = 1'b0;
    tick(8);
    chk("wakeReg", wakeReg, 1'b0);
    nodeDom = 1'b1;
    tick(WAKE + 6);
    chk("rxOut", rxOut, 1'b0);
    nodeDom = 1'b0;
    seen = 1'b0;
    repeat (8) begin
      tick(1);
      seen = seen | wakeEvent;
    end
    chk("wakeEvent", seen, 1'b1);
    chk("wakeReg", wakeReg, 1'b1);
    chk("rxOut", rxOut, 1'b1);
    rd(1'b1);
    chk("wakeReg", wakeReg, 1'b0);
    lowPower = 1'b0;
    uv = 1'b1;
    tick(6);
    txIn = 1'b0;
    tick(2);
    chk("driveDominant", driveDominant, 1'b0);
    uv = 1'b0;
    tick(6);
    chk("driveDominant", driveDominant, 1'b0);
    txIn = 1'b1;
    tick(2);
    txIn = 1'b0;
    tick(2);
    chk("driveDominant", driveDominant, 1'b1);
    uv = 1'b1;
    tick(6);
    chk("driveDominant", driveDominant, 1'b1);
    txIn = 1'b1;
    tick(2);
    txIn = 1'b0;
    tick(2);
    chk("driveDominant", driveDominant, 1'b0);
    // hold disabled by the select bit.
    uv = 1'b0;
    txIn = 1'b1;
    uvSel = 1'b1;
    tick(6);
    uv = 1'b1;
    tick(6);
    txIn = 1'b0;
    tick(2);
    chk("driveDominant", driveDominant, 1'b1);
    wrap_up();
  end

  // The run needs well under a thousand cycles; a hang ends here instead.
  initial begin
    tick(20000);
    errors++;
    wrap_up();
  end
endmodule // tb_lin_phy_control_logic
